// ---- logic/ppr_pkg.sv ----
// Summary of operation
// - code zero drives pin from port latch
// - codes 1 and 3 give serial transmitters
// - codes 8,9,10 give second SPI outputs
// - code 14 gives CAN transmit
// - codes 16 to 19 give compare channels
// - codes 24 to 26 give comparators 1-3
// - codes 50 and 51 give comparators 4-5
// - code 45 sync out, 49 reference clock
// - codes 57 and 58 give SENT outputs
// - no interlock between any selector registers
// - 8-bit input selectors, capture4 upper byte
// - input selector 181 routes input pin 181
// - first output register: pin35 high, pin20 low
// - second output register: pin37 high, pin36 low
// - third output register: pin176 high, pin120 low
// - fourth output register: pin178 high, pin177 low
// - pin120 field exists only on large variant
// - bits 15-14 and 7-6 read zero
package ppr_pkg;
	// ==========================================================
	// sizes
	localparam int         CODE_W        = 6;
	localparam int         SEL_W         = 8;
	localparam int         ADDR_W        = 8;
	localparam int         NUM_PINS      = 8;
	localparam int         NUM_PERIPH_IN = 22;
	localparam int         NUM_IN_PINS   = 256;
	localparam int         NUM_IN_REGS   = 11;
	localparam int         NUM_OUT_REGS  = 4;
	localparam int         HI_LSB        = 8;
	localparam int         CAPTURE_REG   = 3;
	localparam int         PIN120_IDX    = 4;
	localparam logic [7:0] SEL_RESET     = 8'h00;
	localparam logic [5:0] CODE_RESET    = 6'h00;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] IN_BASE       = 8'h00;
	localparam logic [7:0] OUT_BASE      = 8'h40;
	localparam logic [7:0] OUT_END       = 8'h50;
	localparam logic [7:0] CAPTURE_SEL_B = 8'h0C;
	localparam logic [7:0] OUT_SEL_0     = 8'h40;
	localparam logic [7:0] OUT_SEL_1     = 8'h44;
	localparam logic [7:0] OUT_SEL_176   = 8'h48;
	localparam logic [7:0] OUT_SEL_11    = 8'h4C;
	// ==========================================================
	// peripheral input order: selector 2k low byte, 2k+1 high byte
	localparam int PI_INT1 = 0;
	localparam int PI_CAP3 = 6;
	localparam int PI_CAP4 = 7;
	localparam logic [7:0] INPUT_PIN_181 = 8'hB5;
	// ==========================================================
	// output function codes
	localparam logic [5:0] FN_PORT    = 6'h00;
	localparam logic [5:0] FN_SER1    = 6'h01;
	localparam logic [5:0] FN_SER2    = 6'h03;
	localparam logic [5:0] FN_SPI_DO  = 6'h08;
	localparam logic [5:0] FN_SPI_CK  = 6'h09;
	localparam logic [5:0] FN_SPI_SS  = 6'h0A;
	localparam logic [5:0] FN_CAN_TX  = 6'h0E;
	localparam logic [5:0] FN_OC1     = 6'h10;
	localparam logic [5:0] FN_OC2     = 6'h11;
	localparam logic [5:0] FN_OC3     = 6'h12;
	localparam logic [5:0] FN_OC4     = 6'h13;
	localparam logic [5:0] FN_CMP1    = 6'h18;
	localparam logic [5:0] FN_CMP2    = 6'h19;
	localparam logic [5:0] FN_CMP3    = 6'h1A;
	localparam logic [5:0] FN_SYNC    = 6'h2D;
	localparam logic [5:0] FN_REFCLK  = 6'h31;
	localparam logic [5:0] FN_CMP4    = 6'h32;
	localparam logic [5:0] FN_CMP5    = 6'h33;
	localparam logic [5:0] FN_SENT_UNIT_1_OUT   = 6'h39;
	localparam logic [5:0] FN_SENT_UNIT_2_OUT   = 6'h3A;
	// ==========================================================
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- logic/ppr_top.sv ----
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ppr_top #(
	parameter bit LARGE_PACKAGE = 1'b1
) (
	input  wire logic                             clk_i,
	input  wire logic                             rst_i,
	// AXI4-Lite slave
	input  wire logic [ppr_pkg::ADDR_W-1:0]       s_axi_awaddr_i,
	input  wire logic                             s_axi_awvalid_i,
	output logic                                  s_axi_awready_o,
	input  wire logic [31:0]                      s_axi_wdata_i,
	input  wire logic [3:0]                       s_axi_wstrb_i,
	input  wire logic                             s_axi_wvalid_i,
	output logic                                  s_axi_wready_o,
	output logic [1:0]                            s_axi_bresp_o,
	output logic                                  s_axi_bvalid_o,
	input  wire logic                             s_axi_bready_i,
	input  wire logic [ppr_pkg::ADDR_W-1:0]       s_axi_araddr_i,
	input  wire logic                             s_axi_arvalid_i,
	output logic                                  s_axi_arready_o,
	output logic [31:0]                           s_axi_rdata_o,
	output logic [1:0]                            s_axi_rresp_o,
	output logic                                  s_axi_rvalid_o,
	input  wire logic                             s_axi_rready_i,
	// remappable input pins, asynchronous
	input  wire logic [ppr_pkg::NUM_IN_PINS-1:0]  remappable_pin_i,
	// routed peripheral inputs
	output logic [ppr_pkg::NUM_PERIPH_IN-1:0]     periph_in_o,
	// peripheral outputs, same clock
	input  wire logic                             serial1_transmit_i,
	input  wire logic                             serial2_transmit_i,
	input  wire logic                             spi_second_data_out_i,
	input  wire logic                             spi_second_clock_i,
	input  wire logic                             spi_second_slave_select_i,
	input  wire logic                             can_transmit_i,
	input  wire logic [3:0]                       compare_channel_out_i,
	input  wire logic [4:0]                       comparator_out_i,
	input  wire logic                             pwm_timebase_sync_out_i,
	input  wire logic                             reference_clock_out_i,
	input  wire logic [1:0]                       sent_unit_out_i,
	// ordinary port latch per remappable output pin
	input  wire logic [ppr_pkg::NUM_PINS-1:0]     port_latch_i,
	// pin order: 20,35,36,37,120,176,177,178
	output logic [ppr_pkg::NUM_PINS-1:0]          pin_drive_o,
	output logic [ppr_pkg::NUM_PINS-1:0]          pin_remapped_o
);
	import ppr_pkg::*;

	// ==========================================================
	// selector storage
	logic [SEL_W-1:0]    in_sel   [NUM_PERIPH_IN];
	logic [CODE_W-1:0]   pin_code [NUM_PINS];

	// ==========================================================
	// input pin synchronisers
	logic [NUM_IN_PINS-1:0] pin_meta;
	logic [NUM_IN_PINS-1:0] pin_sync;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= remappable_pin_i;
			pin_sync <= pin_meta;
		end
	end

	// ==========================================================
	// input routing: every selector indexes independently, so one pin may feed many inputs
	logic [NUM_PERIPH_IN-1:0] next_periph_in;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PERIPH_IN; gi++) begin : g_in
			assign next_periph_in[gi] = pin_sync[in_sel[gi]];
		end
	endgenerate

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			periph_in_o <= '0;
		end else begin
			periph_in_o <= next_periph_in;
		end
	end

	// ==========================================================
	// output function decode
	function automatic logic [1:0] fn_mux(input logic [CODE_W-1:0] code, input logic lat);
		unique case (code)
			FN_SER1:   fn_mux = {1'b1, serial1_transmit_i};
			FN_SER2:   fn_mux = {1'b1, serial2_transmit_i};
			FN_SPI_DO: fn_mux = {1'b1, spi_second_data_out_i};
			FN_SPI_CK: fn_mux = {1'b1, spi_second_clock_i};
			FN_SPI_SS: fn_mux = {1'b1, spi_second_slave_select_i};
			FN_CAN_TX: fn_mux = {1'b1, can_transmit_i};
			FN_OC1:    fn_mux = {1'b1, compare_channel_out_i[0]};
			FN_OC2:    fn_mux = {1'b1, compare_channel_out_i[1]};
			FN_OC3:    fn_mux = {1'b1, compare_channel_out_i[2]};
			FN_OC4:    fn_mux = {1'b1, compare_channel_out_i[3]};
			FN_CMP1:   fn_mux = {1'b1, comparator_out_i[0]};
			FN_CMP2:   fn_mux = {1'b1, comparator_out_i[1]};
			FN_CMP3:   fn_mux = {1'b1, comparator_out_i[2]};
			FN_CMP4:   fn_mux = {1'b1, comparator_out_i[3]};
			FN_CMP5:   fn_mux = {1'b1, comparator_out_i[4]};
			FN_SYNC:   fn_mux = {1'b1, pwm_timebase_sync_out_i};
			FN_REFCLK: fn_mux = {1'b1, reference_clock_out_i};
			FN_SENT_UNIT_1_OUT:  fn_mux = {1'b1, sent_unit_out_i[0]};
			FN_SENT_UNIT_2_OUT:  fn_mux = {1'b1, sent_unit_out_i[1]};
			// code zero and every unlisted code fall back to the port latch
			default:   fn_mux = {1'b0, lat};
		endcase
	endfunction

	logic [1:0]          pin_sel_out [NUM_PINS];
	logic [NUM_PINS-1:0] next_pin_drive;
	logic [NUM_PINS-1:0] next_pin_remapped;

	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_out
			// always_comb, not assign: the function also reads the peripheral inputs
			always_comb pin_sel_out[gi]  = fn_mux(pin_code[gi], port_latch_i[gi]);
			assign next_pin_drive[gi]    = pin_sel_out[gi][0];
			assign next_pin_remapped[gi] = pin_sel_out[gi][1];
		end
	endgenerate

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_drive_o    <= '0;
			pin_remapped_o <= '0;
		end else begin
			pin_drive_o    <= next_pin_drive;
			pin_remapped_o <= next_pin_remapped;
		end
	end

	// ==========================================================
	// AXI4-Lite write channel: address and data taken in either order
	logic              aw_held;
	logic [ADDR_W-1:0] aw_addr;
	logic              w_held;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              do_write;
	logic              wr_in_hit;
	logic              wr_out_hit;
	logic [3:0]        wr_idx;

	assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
	assign do_write        = aw_held && w_held && !s_axi_bvalid_o;
	assign wr_idx          = aw_addr[5:2];
	assign wr_in_hit       = (aw_addr[7:6] == IN_BASE[7:6]) && (wr_idx < 4'(NUM_IN_REGS));
	assign wr_out_hit      = (aw_addr >= OUT_BASE) && (aw_addr < OUT_END);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_i;
			w_strb <= s_axi_wstrb_i;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= (wr_in_hit || wr_out_hit) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// ==========================================================
	// selector registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int k = 0; k < NUM_PERIPH_IN; k++) in_sel[k] <= SEL_RESET;
		end else if (do_write && wr_in_hit) begin
			for (int k = 0; k < NUM_IN_REGS; k++) begin
				if (wr_idx == 4'(k)) begin
					// even selector in the low byte, odd in the high byte
					if (w_strb[0]) in_sel[2*k]   <= w_data[7:0];
					if (w_strb[1]) in_sel[2*k+1] <= w_data[15:8];
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int m = 0; m < NUM_PINS; m++) pin_code[m] <= CODE_RESET;
		end else if (do_write && wr_out_hit) begin
			for (int m = 0; m < NUM_OUT_REGS; m++) begin
				if (wr_idx[1:0] == 2'(m)) begin
					// bits 15-14 and 7-6 are simply not stored
					if (w_strb[1]) pin_code[2*m+1] <= w_data[HI_LSB+:CODE_W];
					if (w_strb[0] && (LARGE_PACKAGE || (2*m != PIN120_IDX))) begin
						pin_code[2*m] <= w_data[CODE_W-1:0];
					end
				end
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel: one cycle from address to data
	logic [3:0]  rd_idx;
	logic        rd_in_hit;
	logic        rd_out_hit;
	logic [15:0] rd_in_word;
	logic [15:0] rd_out_word;
	logic [31:0] next_rdata;

	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign rd_idx          = s_axi_araddr_i[5:2];
	assign rd_in_hit       = (s_axi_araddr_i[7:6] == IN_BASE[7:6]) && (rd_idx < 4'(NUM_IN_REGS));
	assign rd_out_hit      = (s_axi_araddr_i >= OUT_BASE) && (s_axi_araddr_i < OUT_END);
	assign rd_in_word      = rd_in_hit ? {in_sel[{rd_idx, 1'b1}], in_sel[{rd_idx, 1'b0}]} : '0;
	assign rd_out_word     = {2'b00, pin_code[{rd_idx[1:0], 1'b1}],
		2'b00, pin_code[{rd_idx[1:0], 1'b0}]};
	assign next_rdata      = rd_in_hit ? {16'h0000, rd_in_word}
		: rd_out_hit ? {16'h0000, rd_out_word} : 32'h00000000;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= '0;
			s_axi_rresp_o  <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= next_rdata;
			s_axi_rresp_o  <= (rd_in_hit || rd_out_hit) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_PORT_DEFAULT: assert property ((pin_code[0] == FN_PORT) |=>
		(pin_drive_o[0] == $past(port_latch_i[0])) && !pin_remapped_o[0])
		else $error("code zero did not drive port latch");
	AST_SERIAL2: assert property ((pin_code[1] == FN_SER2) |=>
		pin_drive_o[1] == $past(serial2_transmit_i))
		else $error("serial 2 transmit not routed");
	AST_SPI_CLOCK: assert property ((pin_code[2] == FN_SPI_CK) |=>
		pin_drive_o[2] == $past(spi_second_clock_i))
		else $error("spi clock not routed");
	AST_CAN: assert property ((pin_code[3] == FN_CAN_TX) |=>
		pin_drive_o[3] == $past(can_transmit_i))
		else $error("can transmit not routed");
	AST_COMPARE4: assert property ((pin_code[5] == FN_OC4) |=>
		pin_drive_o[5] == $past(compare_channel_out_i[3]))
		else $error("compare channel 4 not routed");
	AST_CMP3: assert property ((pin_code[6] == FN_CMP3) |=>
		pin_drive_o[6] == $past(comparator_out_i[2]))
		else $error("comparator 3 not routed");
	AST_CMP5: assert property ((pin_code[7] == FN_CMP5) |=>
		pin_drive_o[7] == $past(comparator_out_i[4]))
		else $error("comparator 5 not routed");
	AST_REFCLK: assert property ((pin_code[0] == FN_REFCLK) |=>
		pin_drive_o[0] == $past(reference_clock_out_i) && pin_remapped_o[0])
		else $error("reference clock not routed");
	AST_SENT_UNIT_1_OUT: assert property ((pin_code[1] == FN_SENT_UNIT_1_OUT) |=>
		pin_drive_o[1] == $past(sent_unit_out_i[0]))
		else $error("sent 1 not routed");
	AST_UNDEF_CODE: assert property ((pin_code[2] == 6'h02) |=>
		!pin_remapped_o[2] && pin_drive_o[2] == $past(port_latch_i[2]))
		else $error("undefined code left port control");
	AST_PIN181: assert property ((in_sel[PI_CAP4] == INPUT_PIN_181) |=>
		periph_in_o[PI_CAP4] == $past(pin_sync[181]))
		else $error("input pin 181 not routed");
	AST_CAPTURE_BYTES: assert property ((do_write && aw_addr == CAPTURE_SEL_B
		&& &w_strb[1:0]) |=> (in_sel[PI_CAP4] == $past(w_data[15:8]))
		&& (in_sel[PI_CAP3] == $past(w_data[7:0])))
		else $error("capture selector bytes misplaced");
	AST_RESERVED_ZERO: assert property ((s_axi_arvalid_i && s_axi_arready_o
		&& rd_out_hit) |=> s_axi_rdata_o[15:14] == 2'b00 && s_axi_rdata_o[7:6] == 2'b00)
		else $error("reserved output bits read nonzero");
	AST_PIN120_ABSENT: assert property (!LARGE_PACKAGE |->
		pin_code[PIN120_IDX] == CODE_RESET)
		else $error("pin 120 field present on small variant");
	AST_WRITE_RESP: assert property (do_write |=> s_axi_bvalid_o
		&& ((s_axi_bresp_o == RESP_OKAY) == $past(wr_in_hit || wr_out_hit)))
		else $error("write response missing or wrong");
	AST_SERIAL1: assert property ((pin_code[4] == FN_SER1) |=>
		pin_drive_o[4] == $past(serial1_transmit_i))
		else $error("serial 1 transmit not routed");
	AST_SPI_DATA: assert property ((pin_code[5] == FN_SPI_DO) |=>
		pin_drive_o[5] == $past(spi_second_data_out_i))
		else $error("spi data not routed");
	AST_SPI_SELECT: assert property ((pin_code[6] == FN_SPI_SS) |=>
		pin_drive_o[6] == $past(spi_second_slave_select_i))
		else $error("spi select not routed");
	AST_COMPARE1: assert property ((pin_code[7] == FN_OC1) |=>
		pin_drive_o[7] == $past(compare_channel_out_i[0]))
		else $error("compare channel 1 not routed");
	AST_COMPARE2: assert property ((pin_code[0] == FN_OC2) |=>
		pin_drive_o[0] == $past(compare_channel_out_i[1]))
		else $error("compare channel 2 not routed");
	AST_COMPARE3: assert property ((pin_code[1] == FN_OC3) |=>
		pin_drive_o[1] == $past(compare_channel_out_i[2]))
		else $error("compare channel 3 not routed");
	AST_CMP1: assert property ((pin_code[3] == FN_CMP1) |=>
		pin_drive_o[3] == $past(comparator_out_i[0]))
		else $error("comparator 1 not routed");
	AST_CMP2: assert property ((pin_code[4] == FN_CMP2) |=>
		pin_drive_o[4] == $past(comparator_out_i[1]))
		else $error("comparator 2 not routed");
	AST_CMP4: assert property ((pin_code[5] == FN_CMP4) |=>
		pin_drive_o[5] == $past(comparator_out_i[3]))
		else $error("comparator 4 not routed");
	AST_SYNC: assert property ((pin_code[6] == FN_SYNC) |=>
		pin_drive_o[6] == $past(pwm_timebase_sync_out_i))
		else $error("pwm sync not routed");
	AST_SENT_UNIT_2_OUT: assert property ((pin_code[7] == FN_SENT_UNIT_2_OUT) |=>
		pin_drive_o[7] == $past(sent_unit_out_i[1]))
		else $error("sent 2 not routed");

	// ==========================================================
	// output field placement
	AST_FIELDS_0: assert property ((do_write && aw_addr == OUT_SEL_0
		&& &w_strb[1:0]) |=> pin_code[1] == $past(w_data[HI_LSB+:CODE_W])
		&& pin_code[0] == $past(w_data[CODE_W-1:0]))
		else $error("output register 0 fields misplaced");
	AST_FIELDS_1: assert property ((do_write && aw_addr == OUT_SEL_1
		&& &w_strb[1:0]) |=> pin_code[3] == $past(w_data[HI_LSB+:CODE_W])
		&& pin_code[2] == $past(w_data[CODE_W-1:0]))
		else $error("output register 1 fields misplaced");
	AST_FIELDS_176: assert property ((do_write && aw_addr == OUT_SEL_176
		&& &w_strb[1:0]) |=> pin_code[5] == $past(w_data[HI_LSB+:CODE_W])
		&& (pin_code[4] == $past(w_data[CODE_W-1:0]) || !LARGE_PACKAGE))
		else $error("pin 176 register fields misplaced");
	AST_FIELDS_11: assert property ((do_write && aw_addr == OUT_SEL_11
		&& &w_strb[1:0]) |=> pin_code[7] == $past(w_data[HI_LSB+:CODE_W])
		&& pin_code[6] == $past(w_data[CODE_W-1:0]))
		else $error("output register 11 fields misplaced");

	// ==========================================================
	// bus answers and reset
	AST_READ_RESP: assert property ((s_axi_arvalid_i && s_axi_arready_o) |=> s_axi_rvalid_o
		&& ((s_axi_rresp_o == RESP_OKAY) == $past(rd_in_hit || rd_out_hit)))
		else $error("read answer missing or wrong");
	AST_RESET_CLEAR: assert property ($fell(rst_i) |-> (pin_drive_o == '0)
		&& (pin_remapped_o == '0) && (periph_in_o == '0) && (pin_code[0] == CODE_RESET))
		else $error("outputs not cleared by reset");

	COV_REMAP: cover property (pin_code[0] == FN_SER1 ##1 pin_remapped_o[0]);
	COV_UNDEF: cover property (pin_code[2] == 6'h3F ##1 !pin_remapped_o[2]);
	COV_ONE_TO_MANY: cover property (pin_code[0] != FN_PORT && pin_code[0] == pin_code[1]);
	COV_W_BEFORE_AW: cover property (w_held && !aw_held ##1 do_write);
	COV_PIN181: cover property (in_sel[PI_CAP4] == INPUT_PIN_181);
endmodule
`default_nettype wire

// ---- sim/peripheral_pin_remap_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_remap_tb;
	import ppr_pkg::*;
	logic clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr, drive, remap, latch;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, oc;
	logic [1:0] bresp, rresp, sent;
	logic [255:0] pins;
	logic [21:0] pin_in;
	logic s1, s2, sdo, sck, ss, can, sync, rck;
	logic [4:0] cmp;
	logic [26:0] src;
	logic [7:0] sel_sh [22];
	logic [5:0] code_sh [8];
	int bad_count, tests_run;
	assign src = {latch, sent, rck, sync, cmp, oc, can, ss, sck, sdo, s2, s1};
	initial begin
		clk_i = 0;
		forever #2 clk_i = ~clk_i;
	end
	ppr_top uut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .remappable_pin_i(pins), .periph_in_o(pin_in),
		.serial1_transmit_i(s1), .serial2_transmit_i(s2), .spi_second_data_out_i(sdo),
		.spi_second_clock_i(sck), .spi_second_slave_select_i(ss), .can_transmit_i(can),
		.compare_channel_out_i(oc), .comparator_out_i(cmp), .pwm_timebase_sync_out_i(sync),
		.reference_clock_out_i(rck), .sent_unit_out_i(sent), .port_latch_i(latch),
		.pin_drive_o(drive), .pin_remapped_o(remap));
	ppr_periph_model far (.clk_i(clk_i), .rst_i(rst_i), .ser1_o(s1), .ser2_o(s2), .sdo_o(sdo),
		.sck_o(sck), .ss_o(ss), .can_o(can), .oc_o(oc), .cmp_o(cmp), .sync_o(sync),
		.refclk_o(rck), .sent_o(sent), .latch_o(latch));
	// ==========================================================
	// checking
	task automatic final_report();
		if (bad_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [1:0] exp_pin(input logic [5:0] c, input logic [26:0] s, input int p);
		case (c)
			FN_SER1: return {1'b1, s[0]};
			FN_SER2: return {1'b1, s[1]};
			FN_SPI_DO: return {1'b1, s[2]};
			FN_SPI_CK: return {1'b1, s[3]};
			FN_SPI_SS: return {1'b1, s[4]};
			FN_CAN_TX: return {1'b1, s[5]};
			FN_OC1: return {1'b1, s[6]};
			FN_OC2: return {1'b1, s[7]};
			FN_OC3: return {1'b1, s[8]};
			FN_OC4: return {1'b1, s[9]};
			FN_CMP1: return {1'b1, s[10]};
			FN_CMP2: return {1'b1, s[11]};
			FN_CMP3: return {1'b1, s[12]};
			FN_CMP4: return {1'b1, s[13]};
			FN_CMP5: return {1'b1, s[14]};
			FN_SYNC: return {1'b1, s[15]};
			FN_REFCLK: return {1'b1, s[16]};
			FN_SENT_UNIT_1_OUT: return {1'b1, s[17]};
			FN_SENT_UNIT_2_OUT: return {1'b1, s[18]};
			default: return {1'b0, s[19+p]};
		endcase
	endfunction
	// ==========================================================
	// bus master
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic ah, wh, bh;
		int n;
		bh = 0;
		n = 0;
		r = 2'h1;
		@(posedge clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bh && n < 40) begin
			@(negedge clk_i);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid & bready;
			if (bh) r = bresp;
			@(posedge clk_i);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (bh) bready <= 1'b0;
			n++;
		end
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rh;
		int n;
		rh = 0;
		n = 0;
		r = 2'h1;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rh && n < 40) begin
			@(negedge clk_i);
			ah = arvalid & arready;
			rh = rvalid & rready;
			if (rh) begin
				r = rresp;
				d = rdata;
			end
			@(posedge clk_i);
			if (ah) arvalid <= 1'b0;
			if (rh) rready <= 1'b0;
			n++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
		logic [1:0] r;
		int i;
		axi_write(a, {16'h0000, d}, s, r);
		chk("bresp", 32'(RESP_OKAY), 32'(r));
		i = int'(a[5:2]);
		if (a[6] && s[0]) code_sh[2*i] = d[5:0];
		if (a[6] && s[1]) code_sh[2*i+1] = d[13:8];
		if (!a[6] && s[0]) sel_sh[2*i] = d[7:0];
		if (!a[6] && s[1]) sel_sh[2*i+1] = d[15:8];
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		chk("rresp", 32'(RESP_OKAY), 32'(r));
		chk("rdata", e, d);
	endtask
	task automatic check_pins();
		logic [26:0] s;
		repeat (2) begin
			@(negedge clk_i);
			s = src;
			@(negedge clk_i);
			for (int p = 0; p < 8; p++)
				chk("pin", 32'(exp_pin(code_sh[p], s, p)), 32'({remap[p], drive[p]}));
		end
	endtask
	task automatic check_in(input logic [255:0] p);
		@(posedge clk_i);
		pins <= p;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		for (int k = 0; k < 22; k++)
			chk("periph_in", 32'(p[sel_sh[k]]), 32'(pin_in[k]));
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (sel_sh[k]) sel_sh[k] = SEL_RESET;
		foreach (code_sh[k]) code_sh[k] = CODE_RESET;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset_vals();
		for (int k = 0; k < 11; k++) rd_chk(8'(4*k), 32'h0);
		for (int k = 0; k < 4; k++) rd_chk(OUT_BASE + 8'(4*k), 32'h0);
		check_pins();
	endtask
	task automatic t_codes();
		logic [5:0] cl [22];
		cl = '{FN_PORT, FN_SER1, FN_SER2, FN_SPI_DO, FN_SPI_CK, FN_SPI_SS, FN_CAN_TX, FN_OC1,
			FN_OC2, FN_OC3, FN_OC4, FN_CMP1, FN_CMP2, FN_CMP3, FN_SYNC, FN_REFCLK, FN_CMP4,
			FN_CMP5, FN_SENT_UNIT_1_OUT, FN_SENT_UNIT_2_OUT, 6'h02, 6'h3F};
		foreach (cl[i]) begin
			// every pin gets every code, so each routing is seen on each pin
			for (int k = 0; k < 4; k++)
				wr(OUT_BASE + 8'(4*k), {2'b00, cl[i], 2'b00, cl[i]}, 4'h3);
			check_pins();
		end
	endtask
	task automatic t_fields();
		logic [5:0] hi [4];
		hi = '{FN_SER1, FN_SPI_CK, FN_CMP4, FN_REFCLK};
		for (int k = 0; k < 4; k++) wr(OUT_BASE + 8'(4*k), {2'b00, hi[k], 2'b00, FN_OC1 + 6'(k)}, 4'h3);
		check_pins();
		for (int k = 0; k < 4; k++) begin
			wr(OUT_BASE + 8'(4*k), 16'hFFFF, 4'hF);
			rd_chk(OUT_BASE + 8'(4*k), 32'h3F3F);
			wr(OUT_BASE + 8'(4*k), 16'h0000, 4'h1);
			rd_chk(OUT_BASE + 8'(4*k), 32'h3F00);
		end
		check_pins();
	endtask
	task automatic t_inputs();
		for (int k = 0; k < 11; k++)
			wr(8'(4*k), (k == 3) ? {INPUT_PIN_181, 8'h2A} : 16'(k*5911+77), 4'h3);
		rd_chk(CAPTURE_SEL_B, 32'hB52A);
		check_in({8{32'h9E3779B9}});
		check_in(~{8{32'h9E3779B9}});
		check_in(256'h1 << 181);
	endtask
	task automatic t_unmapped();
		logic [31:0] d;
		logic [1:0] r;
		axi_write(8'h80, 32'h0000_3F3F, 4'hF, r);
		chk("bresp", 32'(RESP_SLVERR), 32'(r));
		axi_read(8'h2C, d, r);
		chk("rresp", 32'(RESP_SLVERR), 32'(r));
		chk("rdata", 32'h0, d);
		rd_chk(IN_BASE, {16'h0000, sel_sh[1], sel_sh[0]});
		rd_chk(OUT_SEL_0, 32'h3F00);
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		final_report();
	end
	initial begin
		{rst_i, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata, wstrb} = '0;
		pins = '0;
		bad_count = 0;
		tests_run = 0;
		do_reset();
		t_reset_vals();
		t_codes();
		t_fields();
		t_inputs();
		t_unmapped();
		do_reset();
		t_reset_vals();
		final_report();
	end
endmodule
`default_nettype wire

// ---- sim/ppr_periph_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppr_periph_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	output logic            ser1_o,
	output logic            ser2_o,
	output logic            sdo_o,
	output logic            sck_o,
	output logic            ss_o,
	output logic            can_o,
	output logic [3:0]      oc_o,
	output logic [4:0]      cmp_o,
	output logic            sync_o,
	output logic            refclk_o,
	output logic [1:0]      sent_o,
	output logic [7:0]      latch_o
);
	// ==========================================================
	// sources
	// new pattern every cycle, so a stale or swapped route shows up
	logic [26:0] v;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			v <= 27'h5A5A5A5;
		else
			v <= {v[25:0], v[26] ^ v[21] ^ v[3]};
	end
	assign {latch_o, sent_o, refclk_o, sync_o, cmp_o, oc_o, can_o, ss_o, sck_o, sdo_o, ser2_o,
		ser1_o} = v;
endmodule
`default_nettype wire
